// >>> src/isv_top.sv
// Interrupt classification, arbitration and vector address generation.
// Assumes the core and all request sources are synchronous to clock_i.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module isv_top
  import isv_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic boundary_i,
  input wire logic und_i,
  input wire logic into_i,
  input wire logic ovf_flag_i,
  input wire logic brk_i,
  input wire logic int_i,
  input wire logic [5:0] int_num_i,
  input wire logic [7:0] brk_hi_byte_i,
  input wire logic ret_i,
  input wire logic fetch_valid_i,
  input wire logic [19:0] fetch_pc_i,
  input wire logic nmi_n_i,
  input wire logic wdt_req_i,
  input wire logic dbc_req_i,
  input wire logic step_req_i,
  input wire logic [31:0] periph_req_i,
  input wire logic [3:0] alt_req_i,
  output logic busy_o,
  output logic accept_o,
  output logic vec_valid_o,
  output logic [19:0] vec_addr_o,
  output logic [5:0] int_num_o,
  output logic [3:0] int_src_o,
  output logic [2:0] ipl_o,
  output logic iflag_o,
  output logic uflag_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [19:0] vaddr(input logic [19:0] base,
                                         input logic [5:0] num);
    vaddr = base + {12'h000, num, 2'b00};
  endfunction

  // Highest level wins; strict compare keeps the lowest number on a tie
  function automatic logic [8:0] pick(input logic [31:0] pend,
                                       input logic [31:0][2:0] lvl,
                                       input logic [2:0] processor_priority_level);
    logic [8:0] r;
    r = '0;
    for (int k = 4; k < 32; k++) begin
      if (pend[k] && (lvl[k] > processor_priority_level) && (lvl[k] > r[2:0])) begin
        r = {1'b1, 5'(k), lvl[k]};
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] region(input logic [11:0] a);
    region = RG_NONE;
    if (a[1:0] == 2'b00) begin
      if (a == OFF_FLAG) region = RG_FLAG;
      else if (a == OFF_BASE) region = RG_BASE;
      else if (a == OFF_SEL) region = RG_SEL;
      else if (a == OFF_MEN) region = RG_MEN;
      else if (a[11:4] == OFF_MADR[11:4]) region = RG_MADR;
      else if (a == OFF_STAT) region = RG_STAT;
      else if (a[11:7] == OFF_CTRL[11:7]) region = RG_CTRL;
    end
  endfunction

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  isv_state_t q;
  isv_state_t n;
  logic [31:0] preq;
  logic [31:0] clr;
  logic [31:0] rdv;
  logic [8:0] mp;
  logic am_hit;
  logic trap_go;
  logic idle;
  logic acc;
  logic nfall;
  logic wr;
  logic [2:0] rg;
  logic [3:0] src;
  logic [5:0] anum;
  logic [4:0] aidx;
  logic [19:0] avec;
  logic [2:0] alvl;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    n.vld = 1'b0;
    clr = '0;
    rdv = '0;
    // Two-wire mode ack/nack and start/stop arrive on these same lines
    preq = periph_req_i;
    preq[6] = q.sel[SEL_V6] ? alt_req_i[0] : periph_req_i[6];
    preq[7] = q.sel[SEL_V7] ? alt_req_i[1] : periph_req_i[7];
    preq[8] = q.sel[SEL_V8] ? alt_req_i[2] : periph_req_i[8];
    preq[9] = q.sel[SEL_V9] ? alt_req_i[3] : periph_req_i[9];
    preq = preq & ~RSV_MASK;
    am_hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (fetch_valid_i && q.men[i] && (q.madr[i] == fetch_pc_i)) begin
        am_hit = 1'b1;
      end
    end
    mp = pick(q.pend, q.lvl, q.processor_priority_level);
    trap_go = und_i | (into_i & ovf_flag_i) | brk_i | int_i;
    idle = (q.st == ST_IDLE);
    nfall = !q.nmi_low && !nmi_n_i;
    rg = region(paddr_i);
    wr = psel_i && penable_i && pwrite_i;

    // Arbitration: trap instructions bypass every mask
    src = SRC_NONE;
    anum = '0;
    avec = '0;
    alvl = q.processor_priority_level;
    if (idle && boundary_i) begin
      if (und_i) begin
        src = SRC_UND;
        avec = VEC_UND;
      end else if (into_i && ovf_flag_i) begin
        src = SRC_OVF;
        avec = VEC_OVF;
      end else if (brk_i) begin
        src = SRC_BRK;
        avec = (brk_hi_byte_i == BRK_RELOC_BYTE) ?
               vaddr(q.base, 6'h00) : VEC_BRK;
      end else if (int_i) begin
        src = SRC_INT;
        anum = int_num_i;
        avec = vaddr(q.base, int_num_i);
      end else if (q.nmi_pend) begin
        src = SRC_NMI;
        avec = VEC_NMI;
        alvl = IPL_TOP;
      end else if (q.dbc_pend) begin
        src = SRC_DBC;
        avec = VEC_DBC;
      end else if (q.wdt_pend) begin
        src = SRC_WDT;
        avec = VEC_WDT;
        alvl = IPL_TOP;
      end else if (q.step_pend) begin
        src = SRC_STEP;
        avec = VEC_STEP;
      end else if (am_hit) begin
        src = SRC_AM;
        avec = VEC_AM;
      end else if (q.iflag && mp[8]) begin
        src = SRC_MASK;
        anum = {1'b0, mp[7:3]};
        alvl = mp[2:0];
        avec = vaddr(q.base, {1'b0, mp[7:3]});
      end
    end
    acc = (src != SRC_NONE);
    aidx = anum[4:0];

    // Register writes; a zero in the pending bit clears it
    if (wr) begin
      case (rg)
        RG_FLAG: begin
          n.iflag = pwdata_i[FLG_I];
          n.uflag = pwdata_i[FLG_U];
          n.processor_priority_level = pwdata_i[FLG_IPL +: 3];
        end
        RG_BASE: n.base = pwdata_i[19:0];
        RG_SEL: n.sel = pwdata_i[3:0];
        RG_MEN: n.men = pwdata_i[3:0];
        RG_MADR: n.madr[paddr_i[3:2]] = pwdata_i[19:0];
        RG_CTRL: begin
          n.lvl[paddr_i[6:2]] = pwdata_i[2:0];
          clr[paddr_i[6:2]] = !pwdata_i[CTL_PEND];
        end
        default: ;
      endcase
    end

    // Return restores the flags saved at acceptance
    if (ret_i && idle) begin
      n.iflag = q.sv_i;
      n.uflag = q.sv_u;
      n.processor_priority_level = q.sv_ipl;
    end

    if (acc) begin
      n.st = ST_SEQ;
      // Odd base costs split vector fetches
      n.cnt = q.base[0] ? 5'(SEQ_ODD_CYC - 2) :
              5'(SEQ_EVEN_CYC - 2);
      n.vaddr = avec;
      n.num = anum;
      n.src = src;
      n.sv_i = q.iflag;
      n.sv_u = q.uflag;
      n.sv_ipl = q.processor_priority_level;
      n.iflag = 1'b0;
      n.processor_priority_level = alvl;
      if (!(src == SRC_INT && anum >= SOFT_U_KEEP)) begin
        n.uflag = 1'b0;
      end
      if (src == SRC_MASK) begin
        clr[aidx] = 1'b1;
      end
    end else if (q.st == ST_SEQ) begin
      if (q.cnt == 5'h00) begin
        n.st = ST_IDLE;
        n.vld = 1'b1;
      end else begin
        n.cnt = q.cnt - 5'h01;
      end
    end

    // New requests win over any clear in the same cycle
    n.pend = (q.pend & ~clr) | preq;
    n.nmi_pend = (q.nmi_pend && src != SRC_NMI) || nfall;
    n.wdt_pend = (q.wdt_pend && src != SRC_WDT) || wdt_req_i;
    n.dbc_pend = (q.dbc_pend && src != SRC_DBC) || dbc_req_i;
    n.step_pend = (q.step_pend && src != SRC_STEP) || step_req_i;
    n.nmi_low = !nmi_n_i;

    // Read data captured in the setup phase, shown in the access phase
    case (rg)
      RG_FLAG: begin
        rdv[FLG_I] = q.iflag;
        rdv[FLG_U] = q.uflag;
        rdv[FLG_IPL +: 3] = q.processor_priority_level;
      end
      RG_BASE: rdv[19:0] = q.base;
      RG_SEL: rdv[3:0] = q.sel;
      RG_MEN: rdv[3:0] = q.men;
      RG_MADR: rdv[19:0] = q.madr[paddr_i[3:2]];
      RG_STAT: rdv[5:0] = {q.st == ST_SEQ, q.nmi_pend, q.dbc_pend,
                           q.wdt_pend, q.step_pend, q.sv_u};
      RG_CTRL: begin
        rdv[2:0] = q.lvl[paddr_i[6:2]];
        rdv[CTL_PEND] = q.pend[paddr_i[6:2]];
      end
      default: ;
    endcase
    if (psel_i && !penable_i && !pwrite_i) begin
      n.rdata = rdv;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= ISV_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o = q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && (rg == RG_NONE);
  assign busy_o = (q.st == ST_SEQ);
  assign accept_o = acc;
  assign vec_valid_o = q.vld;
  assign vec_addr_o = q.vaddr;
  assign int_num_o = q.num;
  assign int_src_o = q.src;
  assign ipl_o = q.processor_priority_level;
  assign iflag_o = q.iflag;
  assign uflag_o = q.uflag;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int LAT_E = SEQ_EVEN_CYC;
  localparam int LAT_O = SEQ_ODD_CYC;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_acc_even;
    acc && !q.base[0];
  endsequence
  sequence s_acc_odd;
    acc && q.base[0];
  endsequence
  sequence s_soft_lo;
    acc && src == SRC_INT && int_num_i < SOFT_U_KEEP;
  endsequence

  a_mask_gate:
  assert property (acc && src == SRC_MASK |-> q.iflag && alvl > q.processor_priority_level)
    else $error("maskable taken while gated");
  a_trap_free:
  assert property (idle && boundary_i && trap_go |->
                   acc && src >= SRC_UND && src <= SRC_INT)
    else $error("trap not taken");
  a_und_vec:
  assert property (acc && src == SRC_UND |=> vec_addr_o == VEC_UND)
    else $error("wrong undefined opcode vector");
  a_ovf_cond:
  assert property (acc && src == SRC_OVF |-> ovf_flag_i)
    else $error("overflow trap without flag");
  a_brk_reloc:
  assert property (acc && src == SRC_BRK && brk_hi_byte_i == BRK_RELOC_BYTE
                   |=> vec_addr_o == $past(q.base))
    else $error("break not relocated");
  a_ustack_clr:
  assert property (s_soft_lo |=> !q.uflag ##0 q.sv_u == $past(q.uflag))
    else $error("stack select not saved and cleared");
  a_ustack_keep:
  assert property (acc && src == SRC_INT && int_num_i >= SOFT_U_KEEP
                   |=> q.uflag == $past(q.uflag))
    else $error("stack select changed");
  a_nmi_fall:
  assert property ($fell(nmi_n_i) |=> q.nmi_pend)
    else $error("falling edge lost");
  a_seq_even:
  assert property (s_acc_even |-> ##LAT_E vec_valid_o)
    else $error("even sequence length wrong");
  a_seq_odd:
  assert property (s_acc_odd |-> !vec_valid_o [*1] ##LAT_O vec_valid_o)
    else $error("odd sequence length wrong");
  a_pend_clr:
  assert property (acc && src == SRC_MASK && !preq[aidx]
                   |=> !q.pend[$past(aidx)])
    else $error("pending bit not cleared");
  a_rsv_never:
  assert property (acc && src == SRC_MASK |-> !RSV_MASK[aidx])
    else $error("reserved number taken");

endmodule // isv_top

`default_nettype wire

// >>> src/isv_pkg.sv
// Constants, register map and state type of the interrupt vectoring block.
// Assumes a 50 MHz single clock and an APB master with 12-bit byte addresses.
package isv_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_FLAG = 12'h000;
  localparam logic [11:0] OFF_BASE = 12'h004;
  localparam logic [11:0] OFF_SEL = 12'h008;
  localparam logic [11:0] OFF_MEN = 12'h00C;
  localparam logic [11:0] OFF_MADR = 12'h010;
  localparam logic [11:0] OFF_STAT = 12'h020;
  localparam logic [11:0] OFF_CTRL = 12'h080;

  // Region codes from the address decoder
  localparam logic [2:0] RG_NONE = 3'h0;
  localparam logic [2:0] RG_FLAG = 3'h1;
  localparam logic [2:0] RG_BASE = 3'h2;
  localparam logic [2:0] RG_SEL = 3'h3;
  localparam logic [2:0] RG_MEN = 3'h4;
  localparam logic [2:0] RG_MADR = 3'h5;
  localparam logic [2:0] RG_STAT = 3'h6;
  localparam logic [2:0] RG_CTRL = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLG_I = 0;
  localparam int FLG_U = 1;
  localparam int FLG_IPL = 4;
  localparam int CTL_PEND = 3;
  localparam int SEL_V8 = 0;
  localparam int SEL_V9 = 1;
  localparam int SEL_V6 = 2;
  localparam int SEL_V7 = 3;

  // ----------------------------------------------------------------
  // Fixed vectors and table constants
  // ----------------------------------------------------------------
  localparam logic [19:0] VEC_UND = 20'hFFFDC;
  localparam logic [19:0] VEC_OVF = 20'hFFFE0;
  localparam logic [19:0] VEC_BRK = 20'hFFFE4;
  localparam logic [19:0] VEC_AM = 20'hFFFE8;
  localparam logic [19:0] VEC_STEP = 20'hFFFEC;
  localparam logic [19:0] VEC_WDT = 20'hFFFF0;
  localparam logic [19:0] VEC_DBC = 20'hFFFF4;
  localparam logic [19:0] VEC_NMI = 20'hFFFF8;
  localparam logic [7:0] BRK_RELOC_BYTE = 8'hFF;
  localparam logic [31:0] RSV_MASK = 32'h0000200F;
  localparam logic [5:0] SOFT_U_KEEP = 6'h20;
  localparam logic [2:0] IPL_TOP = 3'h7;

  // Interrupt sequence length, accept to vector valid
  localparam int SEQ_EVEN_CYC = 18;
  localparam int SEQ_ODD_CYC = 20;

  // Accepted source codes
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_UND = 4'h1;
  localparam logic [3:0] SRC_OVF = 4'h2;
  localparam logic [3:0] SRC_BRK = 4'h3;
  localparam logic [3:0] SRC_INT = 4'h4;
  localparam logic [3:0] SRC_NMI = 4'h5;
  localparam logic [3:0] SRC_DBC = 4'h6;
  localparam logic [3:0] SRC_WDT = 4'h7;
  localparam logic [3:0] SRC_STEP = 4'h8;
  localparam logic [3:0] SRC_AM = 4'h9;
  localparam logic [3:0] SRC_MASK = 4'hA;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEQ = 2'b10
  } isv_st_t;

  typedef struct packed {
    isv_st_t st;
    logic [4:0] cnt;
    logic iflag;
    logic uflag;
    logic [2:0] processor_priority_level;
    logic sv_i;
    logic sv_u;
    logic [2:0] sv_ipl;
    logic [19:0] base;
    logic [3:0] sel;
    logic [3:0] men;
    logic [3:0][19:0] madr;
    logic [31:0] pend;
    logic [31:0][2:0] lvl;
    logic nmi_pend;
    logic wdt_pend;
    logic dbc_pend;
    logic step_pend;
    logic nmi_low;
    logic vld;
    logic [19:0] vaddr;
    logic [5:0] num;
    logic [3:0] src;
    logic [31:0] rdata;
  } isv_state_t;

  localparam isv_state_t ISV_RST = '{st: ST_IDLE, default: '0};

endpackage

// >>> bench/isv_core_model.sv
// Core-side model: presents one trap instruction at a time to isv_top.
// Assumes the bench pulses go_i for one cycle, never while a trap waits.
`timescale 1ns/1ps
`default_nettype none
module isv_core_model
  import isv_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic accept_i,
  input wire logic go_i,
  input wire logic [1:0] kind_i,
  input wire logic [5:0] num_i,
  output logic boundary_o,
  output logic [3:0] trap_o,
  output logic [5:0] int_num_o
);
  // ----------------------------------------------------------------
  // Trap presentation
  // ----------------------------------------------------------------
  // Held until accepted, since a refused trap must be shown again
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boundary_o <= 1'b0;
      trap_o <= 4'h0;
      int_num_o <= 6'h00;
    end else begin
      boundary_o <= 1'b1;
      if (go_i) begin
        trap_o <= 4'(1 << kind_i);
        int_num_o <= num_i;
      end else if (accept_i && (trap_o != 4'h0)) begin
        trap_o <= 4'h0;
        // Released number shows its inverse, not the old one
        int_num_o <= ~int_num_o;
      end
    end
  end
endmodule // isv_core_model
`default_nettype wire

// >>> bench/isv_top_bench.sv
// Testbench for isv_top: APB register access and vectoring scenarios.
// Assumes isv_core_model drives the trap lines; 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module isv_top_bench
  import isv_pkg::*;
();
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, periph = 32'h0;
  logic ovf = 1'b0, ret = 1'b0, fetch_v = 1'b0, nmi_n = 1'b1, wdt = 1'b0;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [5:0] tnum = 6'h00;
  logic [7:0] brk_byte = 8'h00;
  logic [19:0] fetch_pc = 20'h00000;
  logic [3:0] alt = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, accept, vec_valid, iflag, uflag, boundary;
  logic [19:0] vec_addr;
  logic [5:0] int_num, num_tr;
  logic [3:0] int_src, trap;
  logic [2:0] processor_priority_level;
  int bad_count = 0;
  int num_checks = 0;

  always #10 clock_i = ~clock_i;

  isv_top uut (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .boundary_i(boundary), .und_i(trap[0]),
    .into_i(trap[1]), .ovf_flag_i(ovf), .brk_i(trap[2]), .int_i(trap[3]),
    .int_num_i(num_tr), .brk_hi_byte_i(brk_byte), .ret_i(ret),
    .fetch_valid_i(fetch_v), .fetch_pc_i(fetch_pc), .nmi_n_i(nmi_n),
    .wdt_req_i(wdt), .dbc_req_i(1'b0), .step_req_i(1'b0),
    .periph_req_i(periph), .alt_req_i(alt), .busy_o(busy),
    .accept_o(accept), .vec_valid_o(vec_valid), .vec_addr_o(vec_addr),
    .int_num_o(int_num), .int_src_o(int_src), .ipl_o(processor_priority_level),
    .iflag_o(iflag), .uflag_o(uflag));

  isv_core_model core (.clock_i(clock_i), .resetn_i(resetn_i),
    .accept_i(accept), .go_i(go), .kind_i(kind), .num_i(tnum),
    .boundary_o(boundary), .trap_o(trap), .int_num_o(num_tr));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int i;
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i) penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock_i);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      bad_count++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task rdc(input string what, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q, x);
  endtask

  task trap_go(input logic [1:0] k, input logic [5:0] n, input logic ov,
               input logic [7:0] by);
    @(posedge clock_i);
    go <= 1'b1;
    kind <= k;
    tnum <= n;
    ovf <= ov;
    brk_byte <= by;
    @(posedge clock_i) go <= 1'b0;
  endtask

  task preq(input logic [31:0] p, input logic [3:0] al);
    @(posedge clock_i);
    periph <= p;
    alt <= al;
    @(posedge clock_i);
    periph <= 32'h0;
    alt <= 4'h0;
  endtask

  // Accept seen in cycle c0, vector valid counted in later cycles
  task take(input logic [19:0] va, input logic [3:0] src, input int cyc);
    int i, n;
    for (i = 0; i < 100; i++) begin
      @(negedge clock_i);
      if (accept === 1'b1) break;
    end
    if (i == 100) begin
      bad_count++;
      summarize();
    end
    @(posedge clock_i) fetch_v <= 1'b0;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
      if (n == 1) check("busy", 32'(busy), 32'h1);
    end while (vec_valid !== 1'b1 && n < 60);
    if (vec_valid !== 1'b1) begin
      bad_count++;
      summarize();
    end
    check("cycles", n, cyc);
    check("vector", 32'(vec_addr), 32'(va));
    check("source", 32'(int_src), 32'(src));
  endtask

  task none(input int n);
    int i, c;
    c = 0;
    for (i = 0; i < n; i++) begin
      @(negedge clock_i);
      if (accept === 1'b1) c++;
    end
    check("no_accept", c, 0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [31:0] q;
    logic e;
    rdc("flag", OFF_FLAG, 32'h0);
    rdc("base", OFF_BASE, 32'h0);
    rdc("ctrl21", 12'h0D4, 32'h0);
    apb(1'b0, 12'h040, 32'h0, q, e);
    check("unmapped", 32'(e), 32'h1);
    $display("test reset done");
  endtask

  task t_soft;
    wr(OFF_BASE, 32'h40000);
    wr(OFF_FLAG, 32'h70);
    trap_go(2'h0, 6'h00, 1'b0, 8'h00);
    take(VEC_UND, SRC_UND, SEQ_EVEN_CYC);
    trap_go(2'h1, 6'h00, 1'b0, 8'h00);
    none(10);
    @(posedge clock_i) ovf <= 1'b1;
    take(VEC_OVF, SRC_OVF, SEQ_EVEN_CYC);
    trap_go(2'h2, 6'h00, 1'b0, 8'h00);
    take(VEC_BRK, SRC_BRK, SEQ_EVEN_CYC);
    trap_go(2'h2, 6'h00, 1'b0, 8'hFF);
    take(20'h40000, SRC_BRK, SEQ_EVEN_CYC);
    $display("test soft done");
  endtask

  task t_int;
    wr(OFF_FLAG, 32'h2);
    trap_go(2'h3, 6'h05, 1'b0, 8'h00);
    take(20'h40014, SRC_INT, SEQ_EVEN_CYC);
    check("num", 32'(int_num), 32'h5);
    check("u_clear", 32'(uflag), 32'h0);
    @(posedge clock_i) ret <= 1'b1;
    @(posedge clock_i) ret <= 1'b0;
    @(negedge clock_i);
    check("u_back", 32'(uflag), 32'h1);
    wr(OFF_BASE, 32'h40001);
    trap_go(2'h3, 6'h28, 1'b0, 8'h00);
    take(20'h400A1, SRC_INT, SEQ_ODD_CYC);
    check("u_keep", 32'(uflag), 32'h1);
    trap_go(2'h3, 6'h01, 1'b0, 8'h00);
    take(20'h40005, SRC_INT, SEQ_ODD_CYC);
    wr(OFF_BASE, 32'h40000);
    $display("test int done");
  endtask

  task t_special;
    @(posedge clock_i) nmi_n <= 1'b0;
    take(VEC_NMI, SRC_NMI, SEQ_EVEN_CYC);
    check("ipl_nmi", 32'(processor_priority_level), 32'h7);
    @(posedge clock_i) nmi_n <= 1'b1;
    none(5);
    // Software side restarts the watchdog; nothing to re-arm here
    @(posedge clock_i) wdt <= 1'b1;
    @(posedge clock_i) wdt <= 1'b0;
    take(VEC_WDT, SRC_WDT, SEQ_EVEN_CYC);
    wr(OFF_MEN, 32'h2);
    wr(OFF_MADR, 32'h23456);
    wr(12'h014, 32'h12345);
    @(posedge clock_i);
    fetch_v <= 1'b1;
    fetch_pc <= 20'h23456;
    none(5);
    @(posedge clock_i) fetch_pc <= 20'h12345;
    take(VEC_AM, SRC_AM, SEQ_EVEN_CYC);
    $display("test special done");
  endtask

  task t_mask;
    int j, v;
    int sb[4];
    sb = '{SEL_V6, SEL_V7, SEL_V8, SEL_V9};
    wr(12'h0D4, 32'h3);
    wr(OFF_FLAG, 32'h0);
    preq(32'h00200000, 4'h0);
    none(5);
    rdc("pend_set", 12'h0D4, 32'hB);
    wr(OFF_FLAG, 32'h1);
    take(20'h40054, SRC_MASK, SEQ_EVEN_CYC);
    check("ipl_lvl", 32'(processor_priority_level), 32'h3);
    check("i_clear", 32'(iflag), 32'h0);
    rdc("pend_clr", 12'h0D4, 32'h3);
    wr(12'h0D8, 32'h3);
    wr(OFF_FLAG, 32'h0);
    preq(32'h00600000, 4'h0);
    wr(OFF_FLAG, 32'h1);
    take(20'h40054, SRC_MASK, SEQ_EVEN_CYC);
    wr(OFF_FLAG, 32'h1);
    take(20'h40058, SRC_MASK, SEQ_EVEN_CYC);
    wr(12'h0DC, 32'h2);
    wr(OFF_FLAG, 32'h21);
    preq(32'h00800000, 4'h0);
    none(5);
    wr(OFF_FLAG, 32'h11);
    take(20'h4005C, SRC_MASK, SEQ_EVEN_CYC);
    wr(12'h084, 32'h7);
    wr(OFF_FLAG, 32'h1);
    preq(32'h01000002, 4'h0);
    none(5);
    for (j = 0; j < 4; j++) begin
      v = 6 + j;
      wr(12'(12'h080 + 4 * v), 32'h1);
      wr(OFF_SEL, 32'h0);
      wr(OFF_FLAG, 32'h1);
      preq(32'h0, 4'(1 << j));
      none(5);
      wr(OFF_SEL, 32'(1 << sb[j]));
      preq(32'h0, 4'(1 << j));
      take(20'h40000 + 20'(4 * v), SRC_MASK, SEQ_EVEN_CYC);
    end
    $display("test mask done");
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset();
    t_soft();
    t_int();
    t_special();
    t_mask();
    summarize();
  end
endmodule // isv_top_bench
`default_nettype wire
